// ---- rtl/crb_pkg.sv ----
// Constants, encodings and state types of the bulk-out command decoder.
// Assumes little-endian multi-byte header fields and a single card slot.
package crb_pkg;

   // Message type codes
   localparam logic [7:0] MT_SLOT_OFF    = 8'h63;
   localparam logic [7:0] MT_SLOT_STATUS = 8'h65;
   localparam logic [7:0] MT_XFR_BLOCK   = 8'h6f;
   localparam logic [7:0] MT_GET_PARAM   = 8'h6c;
   localparam logic [7:0] MT_RESET_PARAM = 8'h6d;

   // Header layout, byte offsets
   localparam int OFS_TYPE  = 0;
   localparam int OFS_LEN   = 1;
   localparam int OFS_SLOT  = 5;
   localparam int OFS_SEQ   = 6;
   localparam int OFS_BWI   = 7;
   localparam int OFS_LVL   = 8;
   localparam int HDR_LEN   = 10;
   localparam int MAX_MSG   = 271;
   localparam logic [31:0] MAX_PAY = 32'h0000_0105;   // Largest message minus header
   localparam logic [31:0] LEN_NONE = 32'h0000_0000;
   localparam logic [7:0]  SLOT_ID  = 8'h00;

   // Level parameter codes
   localparam logic [15:0] LVL_WHOLE = 16'h0000;
   localparam logic [15:0] LVL_BEGIN = 16'h0001;
   localparam logic [15:0] LVL_END   = 16'h0002;
   localparam logic [15:0] LVL_MID   = 16'h0003;
   localparam logic [15:0] LVL_RSP   = 16'h0010;

   // Error codes reported beside an error response
   localparam logic [2:0] ERR_NONE = 3'h0;
   localparam logic [2:0] ERR_TYPE = 3'h1;
   localparam logic [2:0] ERR_SLOT = 3'h2;
   localparam logic [2:0] ERR_LEN  = 3'h3;
   localparam logic [2:0] ERR_LVL  = 3'h4;
   localparam logic [2:0] ERR_TMO  = 3'h5;

   // Register map and fields
   localparam logic [7:0] REG_CTRL   = 8'h00;
   localparam logic [7:0] REG_STATUS = 8'h04;
   localparam logic [7:0] REG_COUNT  = 8'h08;
   localparam int CTRL_EXT_BIT   = 0;
   localparam int CTRL_ABORT_BIT = 1;
   localparam logic CTRL_EXT_RST = 1'b1;

   // Timing
   localparam int CLK_NS     = 40;
   localparam int BWT_NS_DEF = 1000000;

   typedef enum logic [1:0] {
      RK_SLOT  = 2'b00,
      RK_DATA  = 2'b01,
      RK_PARAM = 2'b10,
      RK_ERR   = 2'b11
   } crb_rsp_e;

   typedef enum logic [2:0] {
      ST_HDR   = 3'b000,
      ST_EVAL  = 3'b001,
      ST_PAY   = 3'b010,
      ST_WAIT  = 3'b011,
      ST_RESP  = 3'b100,
      ST_DRAIN = 3'b101
   } crb_state_e;

endpackage

// ---- rtl/crb_bwt_timer.sv ----
// Block waiting timer: counts a multiple of the block waiting time.
// Assumes start is a one-cycle pulse and stop holds it idle.
`timescale 1ns/100ps
`default_nettype none
module crb_bwt_timer #(
   parameter int BWT_CYCLES = 25000
) (
   input  wire logic       core_clk,
   input  wire logic       sys_rst,
   input  wire logic       start,
   input  wire logic       stop,
   input  wire logic [7:0] mult,
   output logic            expired
);
   localparam int DW = $clog2(BWT_CYCLES + 1);

   logic [DW-1:0] div_cnt;
   logic [7:0]    unit_cnt;
   logic [7:0]    mult_eff;
   logic          running;
   logic          tick;

   // A zero multiplier would wrap to 256 periods; treat it as one period
   assign mult_eff = (mult == 8'h00) ? 8'h01 : mult;
   assign tick     = running && (div_cnt == DW'(BWT_CYCLES - 1));

   // Divider giving one enable per block waiting time
   always_ff @(posedge core_clk) begin
      if (sys_rst || start || !running) begin
         div_cnt <= '0;
      end else if (tick) begin
         div_cnt <= '0;
      end else begin
         div_cnt <= div_cnt + DW'(1);
      end
   end

   // Period counter and expiry pulse
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         running  <= 1'b0;
         unit_cnt <= 8'h00;
         expired  <= 1'b0;
      end else begin
         expired <= 1'b0;
         if (start) begin
            running  <= 1'b1;
            unit_cnt <= 8'h00;
         end else if (stop) begin
            running <= 1'b0;
         end else if (tick) begin
            if (unit_cnt == mult_eff - 8'h01) begin
               running <= 1'b0;
               expired <= 1'b1;
            end else begin
               unit_cnt <= unit_cnt + 8'h01;
            end
         end
      end
   end
endmodule
`default_nettype wire

// ---- rtl/crb_bulk_decoder.sv ----
// Bulk-out command decoder for a single-slot chip card reader.
// Assumes a byte stream with last marker from the USB side and a card
// transport that takes payload bytes and signals card_done when answered.
`timescale 1ns/100ps
`default_nettype none
module crb_bulk_decoder #(
   parameter int BWT_NS = crb_pkg::BWT_NS_DEF
) (
   input  wire logic              core_clk,
   input  wire logic              sys_rst,
   input  wire logic [7:0]        reg_addr,
   input  wire logic [31:0]       reg_wdata,
   input  wire logic              reg_wr,
   input  wire logic              reg_rd,
   output logic [31:0]            reg_rdata,
   input  wire logic              rx_valid,
   input  wire logic [7:0]        rx_data,
   input  wire logic              rx_last,
   output logic                   rx_ready,
   output logic                   card_valid,
   output logic [7:0]             card_data,
   output logic                   card_last,
   input  wire logic              card_ready,
   input  wire logic              card_done,
   output logic                   rsp_valid,
   input  wire logic              rsp_ready,
   output var crb_pkg::crb_rsp_e  rsp_kind,
   output logic [2:0]             rsp_err,
   output logic [7:0]             rsp_slot,
   output logic [7:0]             rsp_seq,
   output logic                   slot_off,
   output logic                   slot_param_default,
   output logic                   slot_param_query
);
   import crb_pkg::*;

   localparam int BWT_CYCLES = (BWT_NS + CLK_NS - 1) / CLK_NS;

   ////////////////////////////////////////////////////////////////////////
   // Decoding helpers

   function automatic logic no_payload(input logic [7:0] t);
      no_payload = (t == MT_SLOT_OFF) || (t == MT_SLOT_STATUS) ||
                   (t == MT_GET_PARAM) || (t == MT_RESET_PARAM);
   endfunction

   function automatic logic level_known(input logic [15:0] l);
      level_known = (l == LVL_WHOLE) || (l == LVL_BEGIN) || (l == LVL_END) ||
                    (l == LVL_MID) || (l == LVL_RSP);
   endfunction

   crb_state_e  state;
   logic [7:0]  hdr [0:HDR_LEN-1];
   logic [3:0]  byte_cnt;
   logic        hdr_last;
   logic [8:0]  pay_left;
   logic        apdu_end;
   logic        wait_card;
   logic        chain_open;
   logic        ext_mode;
   logic [2:0]  last_err;
   logic [15:0] cmd_count;
   logic        rx_fire;
   logic        tmr_start;
   logic        tmr_expired;
   logic [7:0]  ev_type;
   logic [31:0] ev_len;
   logic [15:0] ev_lvl;
   logic [2:0]  ev_err;
   logic        ev_apdu_end;
   logic        ev_wait;
   logic        sw_abort;

   assign rx_fire   = rx_valid && rx_ready;
   assign rsp_valid = (state == ST_RESP);
   assign sw_abort  = reg_wr && (reg_addr == REG_CTRL) && reg_wdata[CTRL_ABORT_BIT];
   // Timer starts on the edge that enters the wait state; terms kept flat so the
   // assignment sees every signal it depends on
   assign tmr_start = (state == ST_EVAL && ev_err == ERR_NONE && ev_type == MT_XFR_BLOCK &&
                       ev_len == LEN_NONE && ev_wait) ||
                      (state == ST_PAY && rx_fire && pay_left == 9'h001 && rx_last && wait_card);

   // Ready only where a byte can go somewhere; busy states stall the host
   always_comb begin
      case (state)
         ST_HDR:   rx_ready = 1'b1;
         ST_PAY:   rx_ready = !card_valid || card_ready;
         ST_DRAIN: rx_ready = 1'b1;
         default:  rx_ready = 1'b0;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // Header evaluation

   // Checks run on the stored header in a cycle of their own
   always_comb begin
      ev_type = hdr[OFS_TYPE];
      ev_len  = {hdr[OFS_LEN+3], hdr[OFS_LEN+2], hdr[OFS_LEN+1], hdr[OFS_LEN]};
      ev_lvl  = {hdr[OFS_LVL+1], hdr[OFS_LVL]};
      // Short level ignores the level field; reserved bytes never read
      ev_apdu_end = !ext_mode || (ev_lvl == LVL_WHOLE) || (ev_lvl == LVL_END);
      ev_wait     = ev_apdu_end || (ev_lvl == LVL_RSP);
      ev_err      = ERR_NONE;
      if (!no_payload(ev_type) && ev_type != MT_XFR_BLOCK) begin
         ev_err = ERR_TYPE;
      end else if (hdr[OFS_SLOT] != SLOT_ID) begin
         ev_err = ERR_SLOT;
      end else if (no_payload(ev_type) && (ev_len != LEN_NONE || !hdr_last)) begin
         ev_err = ERR_LEN;
      end else if (ev_type == MT_XFR_BLOCK &&
                   (ev_len > MAX_PAY || ((ev_len == LEN_NONE) != hdr_last))) begin
         ev_err = ERR_LEN;
      end else if (ev_type == MT_XFR_BLOCK && ext_mode) begin
         if (!level_known(ev_lvl)) begin
            ev_err = ERR_LVL;
         end else if ((ev_lvl == LVL_END || ev_lvl == LVL_MID) && !chain_open) begin
            ev_err = ERR_LVL;
         end else if (ev_lvl == LVL_RSP && ev_len != LEN_NONE) begin
            ev_err = ERR_LVL;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Message sequencer

   // Header bytes land in the array; byte count never passes the header
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         byte_cnt <= 4'h0;
         hdr_last <= 1'b0;
      end else if (state == ST_HDR && rx_fire) begin
         hdr[byte_cnt] <= rx_data;
         hdr_last      <= rx_last;
         byte_cnt      <= (rx_last || byte_cnt == 4'(HDR_LEN - 1)) ? 4'h0 : byte_cnt + 4'h1;
      end
   end

   // Main state machine
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         state     <= ST_HDR;
         pay_left  <= 9'h000;
         apdu_end  <= 1'b0;
         wait_card <= 1'b0;
      end else begin
         case (state)
            ST_HDR: begin
               if (rx_fire && byte_cnt == 4'(HDR_LEN - 1)) begin
                  state <= ST_EVAL;
               end else if (rx_fire && rx_last) begin
                  state <= ST_RESP; // Runt message
               end
            end
            ST_EVAL: begin
               pay_left  <= ev_len[8:0];
               apdu_end  <= ev_apdu_end;
               wait_card <= ev_wait;
               if (ev_err != ERR_NONE) begin
                  state <= hdr_last ? ST_RESP : ST_DRAIN;
               end else if (no_payload(ev_type)) begin
                  state <= ST_RESP;
               end else if (ev_len != LEN_NONE) begin
                  state <= ST_PAY;
               end else begin
                  state <= ev_wait ? ST_WAIT : ST_RESP;
               end
            end
            ST_PAY: begin
               if (rx_fire) begin
                  pay_left <= pay_left - 9'h001;
                  if (rx_last && pay_left == 9'h001) begin
                     state <= wait_card ? ST_WAIT : ST_RESP;
                  end else if (rx_last) begin
                     state <= ST_RESP;
                  end else if (pay_left == 9'h001) begin
                     state <= ST_DRAIN;
                  end
               end
            end
            ST_WAIT: begin
               if (card_done || tmr_expired) begin
                  state <= ST_RESP;
               end
            end
            ST_RESP: begin
               if (rsp_ready) begin
                  state <= ST_HDR;
               end
            end
            ST_DRAIN: begin
               if (rx_fire && rx_last) begin
                  state <= ST_RESP;
               end
            end
            default: state <= ST_HDR;
         endcase
      end
   end

   // Response descriptor; held steady while the host has not taken it
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         rsp_kind <= RK_SLOT;
         rsp_err  <= ERR_NONE;
         rsp_slot <= 8'h00;
         rsp_seq  <= 8'h00;
      end else if (state == ST_HDR && rx_fire && rx_last && byte_cnt != 4'(HDR_LEN - 1)) begin
         rsp_kind <= RK_ERR;
         rsp_err  <= ERR_LEN;
      end else if (state == ST_EVAL) begin
         rsp_slot <= hdr[OFS_SLOT];
         rsp_seq  <= hdr[OFS_SEQ];
         rsp_err  <= ev_err;
         if (ev_err != ERR_NONE) begin
            rsp_kind <= RK_ERR;
         end else if (ev_type == MT_SLOT_OFF || ev_type == MT_SLOT_STATUS) begin
            rsp_kind <= RK_SLOT;
         end else if (ev_type == MT_XFR_BLOCK) begin
            rsp_kind <= RK_DATA;
         end else begin
            rsp_kind <= RK_PARAM;
         end
      end else if (state == ST_PAY && rx_fire && (rx_last != (pay_left == 9'h001))) begin
         rsp_kind <= RK_ERR;
         rsp_err  <= ERR_LEN;
      end else if (state == ST_WAIT && !card_done && tmr_expired) begin
         rsp_kind <= RK_ERR;
         rsp_err  <= ERR_TMO;
      end
   end

   // Slot actions fire only for a clean header, never on an error
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         slot_off           <= 1'b0;
         slot_param_default <= 1'b0;
         slot_param_query   <= 1'b0;
      end else begin
         slot_off           <= (state == ST_EVAL) && ev_err == ERR_NONE &&
                               ev_type == MT_SLOT_OFF;
         slot_param_default <= (state == ST_EVAL) && ev_err == ERR_NONE &&
                               ev_type == MT_RESET_PARAM;
         slot_param_query   <= (state == ST_EVAL) && ev_err == ERR_NONE &&
                               ev_type == MT_GET_PARAM;
      end
   end

   // Open-APDU flag; hardware updates come after the software abort so they win
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         chain_open <= 1'b0;
      end else begin
         if (sw_abort) begin
            chain_open <= 1'b0;
         end
         if (state == ST_EVAL && ev_err == ERR_LVL) begin
            chain_open <= 1'b0;
         end else if (state == ST_EVAL && ev_err == ERR_NONE &&
                      ev_type == MT_XFR_BLOCK && ext_mode) begin
            if (ev_lvl == LVL_BEGIN || ev_lvl == LVL_MID) begin
               chain_open <= 1'b1;
            end else if (ev_lvl == LVL_WHOLE || ev_lvl == LVL_END) begin
               chain_open <= 1'b0;
            end
         end else if (state == ST_WAIT && !card_done && tmr_expired) begin
            chain_open <= 1'b0;
         end
      end
   end

   // One-byte stage toward the card: bytes go through untouched
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         card_valid <= 1'b0;
         card_data  <= 8'h00;
         card_last  <= 1'b0;
      end else if (state == ST_PAY && rx_fire) begin
         card_valid <= 1'b1;
         card_data  <= rx_data;
         card_last  <= apdu_end && (pay_left == 9'h001);
      end else if (card_ready) begin
         card_valid <= 1'b0;
      end
   end

   // Block waiting timeout scaled by the header multiplier
   crb_bwt_timer #(
      .BWT_CYCLES (BWT_CYCLES)
   ) u_timer (
      .core_clk (core_clk),
      .sys_rst  (sys_rst),
      .start    (tmr_start),
      .stop     (state != ST_WAIT),
      .mult     (hdr[OFS_BWI]),
      .expired  (tmr_expired)
   );

   ////////////////////////////////////////////////////////////////////////
   // Register port

   // Control write; extended level on by default
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         ext_mode <= CTRL_EXT_RST;
      end else if (reg_wr && reg_addr == REG_CTRL) begin
         ext_mode <= reg_wdata[CTRL_EXT_BIT];
      end
   end

   // Last error and counter of every response taken, error responses included, for software
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         last_err  <= ERR_NONE;
         cmd_count <= 16'h0000;
      end else if (state == ST_RESP && rsp_ready) begin
         last_err  <= rsp_err;
         cmd_count <= cmd_count + 16'h0001;
      end
   end

   // Read data one cycle after the strobe; unmapped reads give zero
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         reg_rdata <= 32'h0000_0000;
      end else if (!reg_rd) begin
         reg_rdata <= 32'h0000_0000;
      end else if (reg_addr == REG_CTRL) begin
         reg_rdata <= {31'h0, ext_mode};
      end else if (reg_addr == REG_STATUS) begin
         reg_rdata <= {25'h0, last_err, chain_open, state};
      end else if (reg_addr == REG_COUNT) begin
         reg_rdata <= {16'h0, cmd_count};
      end else begin
         reg_rdata <= 32'h0000_0000;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Checks

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (sys_rst);

   property p_off_rsp;
      slot_off |-> rsp_valid && rsp_kind == RK_SLOT && rsp_err == ERR_NONE;
   endproperty
   a_off_rsp: assert property (p_off_rsp) else $error("deactivate without slot status");

   property p_stat_rsp;
      (state == ST_EVAL && ev_err == ERR_NONE && ev_type == MT_SLOT_STATUS)
         |=> rsp_valid && rsp_kind == RK_SLOT && !slot_off;
   endproperty
   a_stat_rsp: assert property (p_stat_rsp) else $error("status query answered wrongly");

   property p_xfr_rsp;
      (state == ST_WAIT && card_done) |=> rsp_valid && rsp_kind == RK_DATA;
   endproperty
   a_xfr_rsp: assert property (p_xfr_rsp) else $error("transfer not answered with data");

   property p_tmo;
      (state == ST_WAIT && tmr_expired && !card_done)
         |=> rsp_valid && rsp_kind == RK_ERR && rsp_err == ERR_TMO && !chain_open;
   endproperty
   a_tmo: assert property (p_tmo) else $error("timeout not reported");

   property p_begin;
      (state == ST_EVAL && ev_err == ERR_NONE && ev_type == MT_XFR_BLOCK &&
       ext_mode && ev_lvl == LVL_BEGIN) |=> chain_open;
   endproperty
   a_begin: assert property (p_begin) else $error("chain not held open");

   property p_card_last;
      (card_valid && card_last) |-> apdu_end;
   endproperty
   a_card_last: assert property (p_card_last) else $error("APDU end in mid chain");

   property p_bad_level;
      (state == ST_EVAL && ev_err == ERR_LVL)
         |=> !chain_open && rsp_kind == RK_ERR && (state == ST_RESP || state == ST_DRAIN);
   endproperty
   a_bad_level: assert property (p_bad_level) else $error("bad level not aborted");

   property p_err_noact;
      (state == ST_EVAL && ev_err != ERR_NONE)
         |=> !slot_off && !slot_param_default && !slot_param_query ##1 !card_valid;
   endproperty
   a_err_noact: assert property (p_err_noact) else $error("slot action on bad command");

   property p_param_rsp;
      (slot_param_default || slot_param_query) |-> rsp_valid && rsp_kind == RK_PARAM;
   endproperty
   a_param_rsp: assert property (p_param_rsp) else $error("parameter command misanswered");

   property p_echo;
      (state == ST_EVAL) |=> rsp_seq == $past(hdr[OFS_SEQ]) && rsp_slot == $past(hdr[OFS_SLOT]);
   endproperty
   a_echo: assert property (p_echo) else $error("slot or sequence not echoed");

   property p_hold;
      (rsp_valid && !rsp_ready) |=> rsp_valid && !rx_ready && $stable(rsp_seq) && $stable(rsp_kind);
   endproperty
   a_hold: assert property (p_hold) else $error("response dropped before taken");

   c_off:   cover property (slot_off);
   c_xfr:   cover property (state == ST_WAIT && card_done);
   c_chain: cover property (chain_open && card_valid && card_last);
   c_tmo:   cover property (state == ST_WAIT && tmr_expired);
endmodule
`default_nettype wire

// ---- tb/crb_host_model.sv ----
// Host side model: sends whole bulk-out messages byte by byte.
// Assumes the decoder raises rx_ready when it takes a byte.
`timescale 1ns/100ps
`default_nettype none
module crb_host_model (
   input  wire logic       core_clk,
   input  wire logic       rx_ready,
   output logic            rx_valid,
   output logic [7:0]      rx_data,
   output logic            rx_last
);
   initial begin
      rx_valid = 1'b0;
      rx_data  = 8'h00;
      rx_last  = 1'b0;
   end
   // Caller builds headers and waits for each response
   // Byte held until taken; released data shows the inverse so a stale value never passes
   task automatic send(input logic [7:0] m[$]);
      @(posedge core_clk);
      foreach (m[i]) begin
         rx_valid <= 1'b1;
         rx_data  <= m[i];
         rx_last  <= (i == m.size() - 1);
         do @(posedge core_clk); while (rx_ready !== 1'b1);
      end
      rx_valid <= 1'b0;
      rx_last  <= 1'b0;
      rx_data  <= ~m[m.size() - 1];
   endtask
endmodule
`default_nettype wire

// ---- tb/tb_top.sv ----
// Self-checking bench of the bulk-out decoder with host and card models.
// Assumes a short block waiting time of ten cycles.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   import crb_pkg::*;
   logic core_clk, sys_rst, reg_wr, reg_rd, rx_valid, rx_last, rx_ready;
   logic card_valid, card_last, card_ready, card_done, rsp_valid, rsp_ready, mute;
   logic slot_off, slot_param_default, slot_param_query;
   logic [2:0] acts;
   logic [7:0] reg_addr, rx_data, card_data, rsp_slot, rsp_seq;
   logic [31:0] reg_wdata, reg_rdata;
   logic [2:0] rsp_err;
   crb_rsp_e rsp_kind;
   logic [23:0] rq[$];
   logic [8:0] cq[$];
   int miscompares, samples_checked, n_rsp, cyc, dly;
   crb_bulk_decoder #(.BWT_NS(400)) DUT (.core_clk, .sys_rst, .reg_addr, .reg_wdata,
      .reg_wr, .reg_rd, .reg_rdata, .rx_valid, .rx_data, .rx_last, .rx_ready,
      .card_valid, .card_data, .card_last, .card_ready, .card_done, .rsp_valid,
      .rsp_ready, .rsp_kind, .rsp_err, .rsp_slot, .rsp_seq, .slot_off,
      .slot_param_default, .slot_param_query);
   crb_host_model h (.core_clk, .rx_ready, .rx_valid, .rx_data, .rx_last);
   initial begin
      core_clk = 1'b0;
      forever #20 core_clk = ~core_clk;
   end
   task automatic check(input string nm, input logic [31:0] seen, exp);
      samples_checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic end_sim;
      if (miscompares == 0 && samples_checked > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////
   // Card model: random stall, answers a few cycles after a complete APDU
   always @(posedge core_clk) begin
      card_ready <= 1'($urandom);
      card_done  <= (dly == 1);
      if (dly > 0) dly--;
      if (card_valid && card_ready) begin
         check("card byte", {card_last, card_data}, cq.size() ? cq.pop_front() : 'x);
         if (card_last && !mute) dly = 3;
      end
   end
   // Response watcher: random host stall, oldest note compared on each take
   always @(posedge core_clk) begin
      rsp_ready <= 1'($urandom);
      if (++cyc == 30000) begin
         miscompares++; // Hang cut short
         end_sim();
      end
      // Slot action pulses gathered since the last take ride along with the response
      acts = acts | {slot_off, slot_param_default, slot_param_query};
      if (rsp_valid && rsp_ready) begin
         check("response", {acts, rsp_kind, rsp_err, rsp_slot, rsp_seq},
               rq.size() ? rq.pop_front() : 'x);
         acts = 3'h0;
         n_rsp++;
      end
   end
   ////////////////////////////////////////////////////////////////////////
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      @(posedge core_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      @(posedge core_clk);
      check("reg read", reg_rdata, e);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask
   // One message; expected card bytes and response noted before sending
   task automatic run(input logic [7:0] t, sl, bwi, input logic [15:0] lvl, input int n,
                      input crb_rsp_e k, input logic [2:0] e, input bit crd);
      logic [7:0] m[$];
      logic [7:0] sq, b;
      logic [2:0] act;
      int c;
      sq = 8'($urandom);
      act = {t == MT_SLOT_OFF, t == MT_RESET_PARAM, t == MT_GET_PARAM};
      m = {t, n[7:0], n[15:8], 8'h00, 8'h00, sl, sq, bwi, lvl[7:0], lvl[15:8]};
      for (int i = 0; i < n; i++) begin
         b = 8'($urandom);
         m.push_back(b);
         if (crd) cq.push_back({(i == n - 1) && lvl != LVL_BEGIN && lvl != LVL_MID, b});
      end
      rq.push_back({act & {3{e == ERR_NONE}}, k, e, sl, sq});
      c = n_rsp;
      h.send(m);
      wait (n_rsp > c);
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      {sys_rst, reg_wr, reg_rd, mute, card_ready, card_done, rsp_ready} = 7'h41;
      {reg_addr, reg_wdata, acts, miscompares, samples_checked, n_rsp, cyc, dly} = '0;
      void'($urandom(32'h7287a5fb));
      repeat (4) @(posedge core_clk);
      sys_rst <= 1'b0;
      mute <= 1'b0;
      rd(REG_CTRL, 32'h0000_0001);
      rd(8'h40, 32'h0000_0000);
      wr(REG_CTRL, 32'h0000_0000);
      rd(REG_CTRL, 32'h0000_0000);
      run(MT_XFR_BLOCK, 8'h00, 8'h04, LVL_WHOLE, 2, RK_DATA, ERR_NONE, 1);
      wr(REG_CTRL, 32'h0000_0001);
      run(MT_SLOT_OFF, 8'h00, 8'h00, 16'h0000, 0, RK_SLOT, ERR_NONE, 0);
      run(MT_SLOT_STATUS, 8'h00, 8'h5a, 16'h0000, 0, RK_SLOT, ERR_NONE, 0);
      run(MT_GET_PARAM, 8'h00, 8'h00, 16'h0000, 0, RK_PARAM, ERR_NONE, 0);
      run(MT_RESET_PARAM, 8'h00, 8'h00, 16'h0000, 0, RK_PARAM, ERR_NONE, 0);
      run(MT_XFR_BLOCK, 8'h00, 8'h04, LVL_WHOLE, 3, RK_DATA, ERR_NONE, 1);
      run(MT_XFR_BLOCK, 8'h00, 8'h01, LVL_BEGIN, 2, RK_DATA, ERR_NONE, 1);
      run(MT_XFR_BLOCK, 8'h00, 8'h01, LVL_MID, 1, RK_DATA, ERR_NONE, 1);
      run(MT_XFR_BLOCK, 8'h00, 8'h04, LVL_END, 2, RK_DATA, ERR_NONE, 1);
      run(MT_XFR_BLOCK, 8'h00, 8'h01, LVL_END, 1, RK_ERR, ERR_LVL, 0);
      run(MT_XFR_BLOCK, 8'h00, 8'h01, 16'h0005, 1, RK_ERR, ERR_LVL, 0);
      run(MT_XFR_BLOCK, 8'h00, 8'h01, LVL_RSP, 2, RK_ERR, ERR_LVL, 0);
      // Software abort closes an open chain, so a continuation is then an orphan
      run(MT_XFR_BLOCK, 8'h00, 8'h01, LVL_BEGIN, 1, RK_DATA, ERR_NONE, 1);
      rd(REG_STATUS, 32'h0000_0008);
      wr(REG_CTRL, 32'h0000_0003);
      rd(REG_STATUS, 32'h0000_0000);
      run(MT_XFR_BLOCK, 8'h00, 8'h01, LVL_MID, 1, RK_ERR, ERR_LVL, 0);
      run(MT_SLOT_STATUS, 8'h01, 8'h00, 16'h0000, 0, RK_ERR, ERR_SLOT, 0);
      run(8'h62, 8'h00, 8'h00, 16'h0000, 0, RK_ERR, ERR_TYPE, 0);
      run(MT_GET_PARAM, 8'h00, 8'h00, 16'h0000, 1, RK_ERR, ERR_LEN, 0);
      mute <= 1'b1;
      run(MT_XFR_BLOCK, 8'h00, 8'h02, LVL_WHOLE, 1, RK_ERR, ERR_TMO, 1);
      rd(REG_STATUS, {25'h0, ERR_TMO, 4'h0});
      rd(REG_COUNT, n_rsp);
      check("card queue", cq.size(), 0);
      end_sim();
   end
endmodule
`default_nettype wire
